// [logic/pport_defines.vh]
// Register map, field positions and field encodings of the parallel port
`ifndef PPORT_DEFINES_VH
`define PPORT_DEFINES_VH
// APB byte addresses
`define ADDR_CONTROL 12'h000
`define ADDR_MODE 12'h004
`define ADDR_ADDRESS 12'h008
`define ADDR_PIN_ENABLE 12'h00c
`define ADDR_STATUS 12'h010
`define ADDR_PAD_CFG 12'h014
`define ADDR_DATA 12'h018
`define ADDR_OUT_WORD_ONE 12'h01c
`define ADDR_OUT_WORD_TWO 12'h020
`define ADDR_IN_WORD_ONE 12'h024
`define ADDR_IN_WORD_TWO 12'h028
// Mode register fields
`define MODE_IRQ_HI 14
`define MODE_IRQ_LO 13
`define MODE_INC_HI 12
`define MODE_INC_LO 11
`define MODE_WIDE 10
`define MODE_SEL_HI 9
`define MODE_SEL_LO 8
`define MODE_SETUP_HI 7
`define MODE_SETUP_LO 6
`define MODE_STROBE_HI 5
`define MODE_STROBE_LO 2
`define MODE_HOLD_HI 1
`define MODE_HOLD_LO 0
// Field encodings
`define PM_LEGACY 2'h0
`define PM_ENHANCED 2'h1
`define PM_MASTER2 2'h2
`define PM_MASTER1 2'h3
`define IRQ_NONE 2'h0
`define IRQ_END_CYCLE 2'h1
`define IRQ_STALL 2'h2
`define IRQ_BUFFER3 2'h3
`define INC_NONE 2'h0
`define INC_UP 2'h1
`define INC_DOWN 2'h2
`define INC_BUFFER 2'h3
// Address register fields
`define ADDR_CS2 15
`define ADDR_CS1 14
`define ADDR_LOW_HI 13
// Status register fields
`define ST_INPUT_OVERFLOW_FLAG 14
`define ST_OUTPUT_UNDERFLOW_FLAG 6
// Control register enable bit
`define CTL_ENABLE 15
`define SLOT_LAST 2'h3
`define RESET_STATUS_EMPTY 4'hf
`endif

// [logic/pin_sync.v]
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module pin_sync #(
   parameter WIDTH = 1
) (
   input wire pclk,
   input wire presetn,
   input wire [WIDTH-1:0] din,
   output reg [WIDTH-1:0] dout
);
   reg [WIDTH-1:0] s1;
   reg [WIDTH-1:0] s2;
   reg [WIDTH-1:0] s3;
   integer i;
   // The first stage feeds only the second stage
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1 <= {WIDTH{1'b0}};
         s2 <= {WIDTH{1'b0}};
         s3 <= {WIDTH{1'b0}};
         dout <= {WIDTH{1'b0}};
      end else begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
         for (i = 0; i < WIDTH; i = i + 1) begin
            if (s2[i] == s3[i]) begin
               dout[i] <= s3[i];
            end
         end
      end
   end
endmodule // pin_sync

// [logic/slot_buffer.v]
// Four-byte slot memory with registered read data
`timescale 1ns/100ps
module slot_buffer #(
   parameter DEPTH_BITS = 2,
   parameter WIDTH = 8
) (
   input wire pclk,
   input wire presetn,
   input wire we,
   input wire [DEPTH_BITS-1:0] waddr,
   input wire [WIDTH-1:0] wdata,
   input wire [DEPTH_BITS-1:0] raddr,
   output reg [WIDTH-1:0] rdata,
   output wire [(WIDTH<<DEPTH_BITS)-1:0] all_data
);
   reg [WIDTH-1:0] mem [0:(1<<DEPTH_BITS)-1];
   integer i;
   genvar g;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (i = 0; i < (1<<DEPTH_BITS); i = i + 1) begin
            mem[i] <= {WIDTH{1'b0}};
         end
         rdata <= {WIDTH{1'b0}};
      end else begin
         if (we) begin
            mem[waddr] <= wdata;
         end
         rdata <= mem[raddr];
      end
   end
   generate
      for (g = 0; g < (1<<DEPTH_BITS); g = g + 1) begin : flat
         assign all_data[g*WIDTH +: WIDTH] = mem[g];
      end
   endgenerate
endmodule // slot_buffer

// [logic/parallel_master_slave_port.v]
// Parallel master/slave port with APB register access
`timescale 1ns/100ps
`include "pport_defines.vh"
// Summary of operation
// - Busy flag reads one during master transfers
// - End-of-cycle interrupt or processor stall option
// - Slave interrupt on buffer three access
// - Address increment, decrement, hold or buffer
// - Wide mode makes two byte transfers
// - Mode field picks master or slave
// - Setup wait one to four cycles
// - Strobe wait adds zero to fifteen
// - Zero strobe wait ignores setup, hold
// - Idle cycle between consecutive operations
// - Address register drives chip selects, address
// - Pad enables fifteen, fourteen to port
// - Pad enables thirteen to two address
// - Pad enables one, zero latch strobes
// - Input slot flags clear on read
// - Output empty flag when all empty
// - Sticky output underflow on empty read
// - Output slot flags set after host read
// - Low address bits select slot byte
module parallel_master_slave_port (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [7:0] port_data_in,
   output reg [7:0] port_data_out,
   output reg port_data_oe,
   output reg [15:0] port_address_lines,
   output reg [15:0] port_address_oe,
   output reg read_strobe,
   output reg write_strobe,
   output reg address_latch_low,
   output reg address_latch_high,
   input wire host_read_n,
   input wire host_write_n,
   input wire host_cs_n,
   input wire [1:0] host_addr,
   output reg port_irq,
   output reg cpu_stall,
   output reg input_threshold_select
);
   // ************************************************
   // States of the master cycle
   // ************************************************
   localparam ST_IDLE = 5'b00001;
   localparam ST_SETUP = 5'b00010;
   localparam ST_STROBE = 5'b00100;
   localparam ST_HOLD = 5'b01000;
   localparam ST_GAP = 5'b10000;

   reg [15:0] port_mode_control;
   reg [15:0] port_address_select;
   reg [15:0] port_pin_enable;
   reg port_enable;
   reg [3:0] in_full;
   reg [3:0] out_empty;
   reg input_overflow_flag;
   reg output_underflow_flag;
   reg [7:0] in_mem [0:3];
   reg [1:0] legacy_slot;
   reg [4:0] state;
   reg [3:0] wait_cnt;
   reg second_byte;
   reg is_read;
   reg [15:0] tx_data;
   reg [15:0] rx_data;
   reg host_rd_q;
   reg host_wr_q;
   wire [2:0] hs;
   wire [1:0] haddr_s;
   wire [7:0] pdin_s;
   wire [31:0] out_flat;
   wire [7:0] out_rdata;

   wire [1:0] irq_mode = port_mode_control[`MODE_IRQ_HI:`MODE_IRQ_LO];
   wire [1:0] inc_mode = port_mode_control[`MODE_INC_HI:`MODE_INC_LO];
   wire [1:0] pmode = port_mode_control[`MODE_SEL_HI:`MODE_SEL_LO];
   wire wide = port_mode_control[`MODE_WIDE];
   wire [3:0] strobe_wait = port_mode_control[`MODE_STROBE_HI:`MODE_STROBE_LO];
   wire [1:0] setup_wait = port_mode_control[`MODE_SETUP_HI:`MODE_SETUP_LO];
   wire [1:0] hold_wait = port_mode_control[`MODE_HOLD_HI:`MODE_HOLD_LO];
   wire is_master = pmode[1];
   wire busy = (state != ST_IDLE);
   wire zero_wait = (strobe_wait == 4'h0);

   wire apb_access = psel && penable && pready;
   wire apb_wr = apb_access && pwrite;
   wire apb_rd = apb_access && !pwrite;

   // ************************************************
   // Host pins
   // ************************************************
   pin_sync #(.WIDTH(13)) host_pins (
      .pclk(pclk),
      .presetn(presetn),
      .din({host_read_n, host_write_n, host_cs_n, host_addr, port_data_in}),
      .dout({hs, haddr_s, pdin_s})
   );
   wire host_rd_act = !hs[2] && !hs[0];
   wire host_wr_act = !hs[1] && !hs[0];
   wire host_rd_evt = host_rd_act && !host_rd_q;
   wire host_wr_evt = host_wr_act && !host_wr_q;
   wire slave_on = port_enable && !is_master;
   // Legacy mode walks the slots itself, enhanced takes the host address
   wire [1:0] host_slot = (pmode == `PM_ENHANCED) ? haddr_s : legacy_slot;
   wire do_host_rd = slave_on && host_rd_evt;
   wire do_host_wr = slave_on && host_wr_evt;

   // ************************************************
   // Output slots, read out by the host
   // ************************************************
   wire out_we = apb_wr && ((paddr == `ADDR_OUT_WORD_ONE) || (paddr == `ADDR_OUT_WORD_TWO));
   wire out_hi_word = (paddr == `ADDR_OUT_WORD_TWO);
   reg out_we_lo_done;
   reg out_hi_word_q;
   reg [7:0] out_hi_byte;
   slot_buffer #(.DEPTH_BITS(2), .WIDTH(8)) out_buf (
      .pclk(pclk),
      .presetn(presetn),
      .we(out_we || out_we_lo_done),
      .waddr(out_we_lo_done ? {out_hi_word_q, 1'b1} : {out_hi_word, 1'b0}),
      .wdata(out_we_lo_done ? out_hi_byte : pwdata[7:0]),
      .raddr(host_slot),
      .rdata(out_rdata),
      .all_data(out_flat)
   );

   // ************************************************
   // APB side and master cycle
   // ************************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_mode_control <= 16'h0000;
         port_address_select <= 16'h0000;
         port_pin_enable <= 16'h0000;
         port_enable <= 1'b0;
         input_threshold_select <= 1'b0;
         in_full <= 4'h0;
         out_empty <= `RESET_STATUS_EMPTY;
         input_overflow_flag <= 1'b0;
         output_underflow_flag <= 1'b0;
         in_mem[0] <= 8'h00;
         in_mem[1] <= 8'h00;
         in_mem[2] <= 8'h00;
         in_mem[3] <= 8'h00;
         legacy_slot <= 2'h0;
         state <= ST_IDLE;
         wait_cnt <= 4'h0;
         second_byte <= 1'b0;
         is_read <= 1'b0;
         tx_data <= 16'h0000;
         rx_data <= 16'h0000;
         host_rd_q <= 1'b1;
         host_wr_q <= 1'b1;
         out_we_lo_done <= 1'b0;
         out_hi_word_q <= 1'b0;
         out_hi_byte <= 8'h00;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         port_irq <= 1'b0;
         cpu_stall <= 1'b0;
         port_data_out <= 8'h00;
         port_data_oe <= 1'b0;
         port_address_lines <= 16'h0000;
         port_address_oe <= 16'h0000;
         read_strobe <= 1'b0;
         write_strobe <= 1'b0;
         address_latch_low <= 1'b0;
         address_latch_high <= 1'b0;
      end else begin
         port_irq <= 1'b0;
         host_rd_q <= host_rd_act;
         host_wr_q <= host_wr_act;
         // Second byte of a word written to an output slot pair
         out_we_lo_done <= out_we;
         if (out_we) begin
            out_hi_word_q <= out_hi_word;
            out_hi_byte <= pwdata[15:8];
         end
         // Ready registered in the setup phase keeps decode registered with no wait cycle
         pslverr <= 1'b0;
         // A data access while the master is busy waits until it is free
         pready <= psel && !penable && !((paddr == `ADDR_DATA) && busy);
         if (psel && penable && !pready && !busy) begin
            pready <= 1'b1;
         end
         cpu_stall <= (irq_mode == `IRQ_STALL) && busy;
         if (apb_wr) begin
            case (paddr)
               `ADDR_CONTROL: begin
                  port_enable <= pwdata[`CTL_ENABLE];
               end
               `ADDR_MODE: begin
                  port_mode_control[14:0] <= pwdata[14:0];
               end
               `ADDR_ADDRESS: begin
                  port_address_select <= pwdata[15:0];
               end
               `ADDR_PIN_ENABLE: begin
                  port_pin_enable <= pwdata[15:0];
               end
               `ADDR_STATUS: begin
                  // Software may only clear the sticky flags
                  if (!pwdata[`ST_INPUT_OVERFLOW_FLAG]) input_overflow_flag <= 1'b0;
                  if (!pwdata[`ST_OUTPUT_UNDERFLOW_FLAG]) output_underflow_flag <= 1'b0;
               end
               `ADDR_PAD_CFG: begin
                  input_threshold_select <= pwdata[0];
               end
               `ADDR_OUT_WORD_ONE: begin
                  out_empty[1:0] <= 2'h0;
               end
               `ADDR_OUT_WORD_TWO: begin
                  out_empty[3:2] <= 2'h0;
               end
               default: ;
            endcase
         end
         if (apb_rd) begin
            case (paddr)
               `ADDR_IN_WORD_ONE: in_full[1:0] <= 2'h0;
               `ADDR_IN_WORD_TWO: in_full[3:2] <= 2'h0;
               default: ;
            endcase
         end
         // Start a master transfer on a data register access
         if (apb_access && (paddr == `ADDR_DATA) && is_master && port_enable && !busy) begin
            is_read <= !pwrite;
            tx_data <= pwdata[15:0];
            second_byte <= 1'b0;
            state <= ST_SETUP;
            wait_cnt <= zero_wait ? 4'h0 : {2'h0, setup_wait};
            port_address_lines <= {port_address_select[`ADDR_CS2],
               port_address_select[`ADDR_CS1],
               port_address_select[`ADDR_LOW_HI:0]};
            port_data_out <= pwdata[7:0];
            port_data_oe <= pwrite;
            address_latch_low <= port_pin_enable[0];
            address_latch_high <= port_pin_enable[1];
         end
         // Gate pads by their enable bits
         port_address_oe <= is_master && port_enable ? port_pin_enable : 16'h0000;
         case (state)
            ST_IDLE: ;
            ST_SETUP: begin
               if (wait_cnt == 4'h0) begin
                  address_latch_low <= 1'b0;
                  address_latch_high <= 1'b0;
                  state <= ST_STROBE;
                  wait_cnt <= strobe_wait;
                  read_strobe <= is_read;
                  write_strobe <= (pmode == `PM_MASTER1) ? 1'b1 : !is_read;
               end else begin
                  wait_cnt <= wait_cnt - 4'h1;
               end
            end
            ST_STROBE: begin
               if (wait_cnt == 4'h0) begin
                  read_strobe <= 1'b0;
                  write_strobe <= 1'b0;
                  if (is_read) begin
                     if (second_byte) rx_data[15:8] <= pdin_s;
                     else rx_data[7:0] <= pdin_s;
                  end
                  state <= ST_HOLD;
                  wait_cnt <= zero_wait ? 4'h0 : {2'h0, hold_wait};
               end else begin
                  wait_cnt <= wait_cnt - 4'h1;
               end
            end
            ST_HOLD: begin
               if (wait_cnt == 4'h0) begin
                  port_data_oe <= 1'b0;
                  state <= ST_GAP;
               end else begin
                  wait_cnt <= wait_cnt - 4'h1;
               end
            end
            ST_GAP: begin
               case (inc_mode)
                  `INC_UP: port_address_select[`ADDR_LOW_HI:0] <=
                     port_address_select[`ADDR_LOW_HI:0] + 14'h0001;
                  `INC_DOWN: port_address_select[`ADDR_LOW_HI:0] <=
                     port_address_select[`ADDR_LOW_HI:0] - 14'h0001;
                  default: ;
               endcase
               if (wide && !second_byte) begin
                  second_byte <= 1'b1;
                  address_latch_low <= port_pin_enable[0];
                  address_latch_high <= port_pin_enable[1];
                  port_data_out <= tx_data[15:8];
                  port_data_oe <= !is_read;
                  wait_cnt <= zero_wait ? 4'h0 : {2'h0, setup_wait};
                  state <= ST_SETUP;
               end else begin
                  state <= ST_IDLE;
                  if (irq_mode == `IRQ_END_CYCLE) port_irq <= 1'b1;
               end
            end
            default: state <= ST_IDLE;
         endcase
         // Slave side: hardware sets win over software clears
         if (do_host_wr) begin
            if (in_full[host_slot]) input_overflow_flag <= 1'b1;
            else begin
               in_mem[host_slot] <= pdin_s;
               in_full[host_slot] <= 1'b1;
            end
         end
         if (do_host_rd) begin
            if (out_empty[host_slot]) output_underflow_flag <= 1'b1;
            out_empty[host_slot] <= 1'b1;
            port_data_out <= out_rdata;
            port_data_oe <= 1'b1;
         end
         if (slave_on && !host_rd_act && !do_host_rd) port_data_oe <= 1'b0;
         if ((do_host_rd || do_host_wr) && (irq_mode == `IRQ_BUFFER3)
            && (host_slot == `SLOT_LAST)) begin
            port_irq <= 1'b1;
         end
         if ((do_host_rd || do_host_wr) && (pmode == `PM_LEGACY)
            && (inc_mode == `INC_BUFFER)) begin
            legacy_slot <= legacy_slot + 2'h1;
         end
         if (psel && !penable && !pwrite) begin
            case (paddr)
               `ADDR_MODE: prdata <= {16'h0000, busy, port_mode_control[14:0]};
               `ADDR_ADDRESS: prdata <= {16'h0000, port_address_select};
               `ADDR_PIN_ENABLE: prdata <= {16'h0000, port_pin_enable};
               `ADDR_CONTROL: prdata <= {16'h0000, port_enable, 15'h0000};
               `ADDR_PAD_CFG: prdata <= {31'h00000000, input_threshold_select};
               `ADDR_STATUS: prdata <= {16'h0000, &in_full, input_overflow_flag, 2'h0,
                  in_full, &out_empty, output_underflow_flag, 2'h0,
                  out_empty};
               `ADDR_DATA: prdata <= {16'h0000, rx_data};
               `ADDR_IN_WORD_ONE: prdata <= {16'h0000, in_mem[1], in_mem[0]};
               `ADDR_IN_WORD_TWO: prdata <= {16'h0000, in_mem[3], in_mem[2]};
               `ADDR_OUT_WORD_ONE: prdata <= {16'h0000, out_flat[15:0]};
               `ADDR_OUT_WORD_TWO: prdata <= {16'h0000, out_flat[31:16]};
               default: prdata <= 32'h00000000;
            endcase
         end
         if (psel && !penable) begin
            case (paddr)
               `ADDR_CONTROL, `ADDR_MODE, `ADDR_ADDRESS, `ADDR_PIN_ENABLE,
               `ADDR_STATUS, `ADDR_PAD_CFG, `ADDR_DATA, `ADDR_OUT_WORD_ONE,
               `ADDR_OUT_WORD_TWO, `ADDR_IN_WORD_ONE, `ADDR_IN_WORD_TWO: pslverr <= 1'b0;
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end
endmodule // parallel_master_slave_port

// [bench/pport_chk.sv]
// Concurrent checks on the parallel port top-level pins
`timescale 1ns/100ps
module pport_chk (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input reg pready,
   input reg port_irq,
   input reg cpu_stall,
   input reg write_strobe,
   input reg address_latch_low,
   input reg [15:0] port_address_oe
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire wr_done = psel && penable && pready && pwrite;
   reg [4:0] strobe_run;
   // Saturates so a stuck strobe still trips the bound
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strobe_run <= 5'h00;
      end else if (write_strobe) begin
         strobe_run <= (strobe_run == 5'h1f) ? strobe_run : strobe_run + 5'h01;
      end else begin
         strobe_run <= 5'h00;
      end
   end
   a_irq_single: assert property (port_irq |=> !port_irq)
      else $error("port interrupt longer than one cycle");
   a_stall_no_irq: assert property (cpu_stall |-> !port_irq)
      else $error("interrupt raised while stalling");
   a_strobe_bound: assert property (strobe_run <= 5'h10)
      else $error("strobe longer than sixteen cycles");
   a_idle_gap: assert property ($fell(write_strobe) |-> !write_strobe [*2])
      else $error("no hold and idle cycle after strobe");
   a_latch_setup: assert property (address_latch_low |-> !write_strobe)
      else $error("address latch overlaps strobe");
   a_setup_first: assert property ($rose(write_strobe) && port_address_oe[0] |->
      $past(address_latch_low)) else $error("strobe without setup phase");
   a_pads_by_write: assert property ($changed(port_address_oe) |->
      $past(wr_done) || $past(wr_done, 2))
      else $error("pad enables changed without a register write");
   a_stall_ends: assert property ($fell(cpu_stall) |-> !write_strobe)
      else $error("stall released during strobe");
endmodule // pport_chk

// [bench/ext_host_model.sv]
// External host and data bus seen from the parallel port pins
`timescale 1ns/100ps
module ext_host_model (
   input wire pclk,
   input wire [7:0] port_data_out,
   input wire port_data_oe,
   output reg host_read_n = 1'b1,
   output reg host_write_n = 1'b1,
   output reg host_cs_n = 1'b1,
   output reg [1:0] host_addr = 2'h0,
   output reg [7:0] port_data_in
);
   reg drive = 1'b0;
   reg [7:0] host_data = 8'h00;
   reg [7:0] idle_pat = 8'h00;
   // Released bus toggles so stale data never looks valid
   always @(posedge pclk) idle_pat <= ~idle_pat;
   always @* port_data_in = drive ? host_data : idle_pat;
   task automatic host_access(input logic wr, input logic [1:0] a, input logic [7:0] d,
      output logic [7:0] q, output logic oe);
      @(posedge pclk);
      host_addr <= a;
      host_cs_n <= 1'b0;
      drive <= wr;
      host_data <= d;
      repeat (2) @(posedge pclk);
      if (wr) host_write_n <= 1'b0;
      else host_read_n <= 1'b0;
      repeat (8) @(posedge pclk);
      q = port_data_out;
      oe = port_data_oe;
      host_write_n <= 1'b1;
      host_read_n <= 1'b1;
      repeat (4) @(posedge pclk);
      host_cs_n <= 1'b1;
      drive <= 1'b0;
      repeat (4) @(posedge pclk);
   endtask
endmodule // ext_host_model

// [bench/parallel_master_slave_port_test.sv]
// Self-checking testbench of the parallel master/slave port
`timescale 1ns/100ps
`include "pport_defines.vh"
module parallel_master_slave_port_test;
   reg pclk = 1'b0;
   reg presetn = 1'b0;
   reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h0;
   wire [31:0] prdata;
   wire pready, pslverr, port_data_oe, read_strobe, write_strobe, address_latch_low;
   wire address_latch_high, host_read_n, host_write_n, host_cs_n, port_irq, cpu_stall;
   wire input_threshold_select;
   wire [7:0] port_data_in, port_data_out;
   wire [15:0] port_address_lines, port_address_oe;
   wire [1:0] host_addr;
   integer checked = 0, miscompares = 0, cycles = 0, irq_cnt = 0, stall_cnt = 0;
   integer w_run = 0, w_last = 0, l_run = 0, l_last = 0;
   reg [7:0] wq[$];
   reg [15:0] w_addr;
   reg [31:0] rd;
   reg err, hoe;
   reg [7:0] hq;
   parallel_master_slave_port parallel_master_slave_port_inst (.pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .port_data_in,
      .port_data_out, .port_data_oe, .port_address_lines, .port_address_oe, .read_strobe,
      .write_strobe, .address_latch_low, .address_latch_high, .host_read_n, .host_write_n,
      .host_cs_n, .host_addr, .port_irq, .cpu_stall, .input_threshold_select);
   ext_host_model ext_host_model_inst (.pclk, .port_data_out, .port_data_oe, .host_read_n,
      .host_write_n, .host_cs_n, .host_addr, .port_data_in);
   always #20 pclk = ~pclk;
   // ******************************
   // Pin monitors and timeout
   // ******************************
   always @(posedge pclk) begin
      cycles = cycles + 1;
      if (port_irq === 1'b1) irq_cnt = irq_cnt + 1;
      if (cpu_stall === 1'b1) stall_cnt = stall_cnt + 1;
      if (address_latch_low === 1'b1) l_run = l_run + 1;
      else if (l_run != 0) begin
         l_last = l_run;
         l_run = 0;
      end
      if (write_strobe === 1'b1) begin
         if (w_run == 0) begin
            wq.push_back(port_data_out);
            w_addr = port_address_lines;
         end
         w_run = w_run + 1;
      end else if (w_run != 0) begin
         w_last = w_run;
         w_run = 0;
      end
      if (cycles == 30000) begin
         miscompares = miscompares + 1;
         give_verdict;
      end
   end
   task check(input logic [31:0] got, input logic [31:0] exp);
      checked = checked + 1;
      if (got !== exp) begin
         miscompares = miscompares + 1;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task give_verdict;
      $display("checks %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Entered just after a rising edge; leaves one idle edge after release
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      integer n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 500) begin
         @(posedge pclk);
         n = n + 1;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 500) check(32'h0, 32'h1);
      @(posedge pclk);
   endtask
   function automatic [31:0] mw(input [1:0] irq, input [1:0] inc, input wide,
      input [1:0] sel, input [1:0] su, input [3:0] st);
      mw = {17'h0, irq, inc, wide, sel, su, st, 2'h1};
   endfunction
   task automatic wait_idle(output logic first_busy);
      integer n;
      n = 0;
      apb(1'b0, `ADDR_MODE, 32'h0);
      first_busy = rd[15];
      while (rd[15] !== 1'b0 && n < 100) begin
         apb(1'b0, `ADDR_MODE, 32'h0);
         n = n + 1;
      end
      check(rd & 32'h8000, 32'h0);
      repeat (4) @(posedge pclk);
   endtask
   task automatic host(input logic wr, input logic [1:0] a, input logic [7:0] d);
      ext_host_model_inst.host_access(wr, a, d, hq, hoe);
   endtask
   task automatic rd_status(input logic [31:0] exp);
      apb(1'b0, `ADDR_STATUS, 32'h0);
      check(rd, exp);
   endtask
   // ******************************
   // Scenarios
   // ******************************
   task automatic test_reset;
      rd_status(32'h008f);
      apb(1'b0, `ADDR_MODE, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, `ADDR_ADDRESS, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, 12'h0fc, 32'h0);
      check({31'h0, err}, 32'h1);
      apb(1'b1, `ADDR_CONTROL, 32'h8000);
      $display("reset test done");
   endtask
   task automatic test_timing;
      logic [1:0] sus[3] = '{2'h3, 2'h0, 2'h2};
      logic [3:0] sts[3] = '{4'h2, 4'hf, 4'h0};
      logic b;
      integer i, irq0;
      apb(1'b1, `ADDR_PIN_ENABLE, 32'hffff);
      apb(1'b1, `ADDR_ADDRESS, 32'hc123);
      for (i = 0; i < 3; i = i + 1) begin
         apb(1'b1, `ADDR_MODE, mw(`IRQ_END_CYCLE, `INC_NONE, 1'b0, `PM_MASTER2, sus[i], sts[i]));
         irq0 = irq_cnt;
         apb(1'b1, `ADDR_DATA, 32'h5a + i);
         wait_idle(b);
         if (sts[i] == 4'hf) check({31'h0, b}, 32'h1);
         check(w_last, 32'(sts[i]) + 1);
         check(l_last, (sts[i] == 4'h0) ? 32'h1 : 32'(sus[i]) + 1);
         check({24'h0, wq[$]}, 32'h5a + i);
         check({16'h0, w_addr}, 32'hc123);
         check({16'h0, port_address_oe}, 32'hffff);
         check(irq_cnt - irq0, 32'h1);
      end
      apb(1'b1, `ADDR_PIN_ENABLE, 32'h3ffc);
      @(posedge pclk);
      check({16'h0, port_address_oe}, 32'h3ffc);
      $display("timing test done");
   endtask
   task automatic test_wide;
      logic b;
      integer n0;
      apb(1'b1, `ADDR_ADDRESS, 32'h0004);
      apb(1'b1, `ADDR_MODE, mw(`IRQ_NONE, `INC_UP, 1'b1, `PM_MASTER2, 2'h0, 4'h1));
      n0 = wq.size();
      apb(1'b1, `ADDR_DATA, 32'hbeef);
      wait_idle(b);
      check(wq.size() - n0, 32'h2);
      check({wq[n0], wq[n0 + 1]}, 32'hefbe);
      apb(1'b0, `ADDR_ADDRESS, 32'h0);
      check(rd, 32'h0006);
      apb(1'b1, `ADDR_MODE, mw(`IRQ_NONE, `INC_DOWN, 1'b0, `PM_MASTER1, 2'h0, 4'h1));
      apb(1'b1, `ADDR_DATA, 32'h11);
      wait_idle(b);
      apb(1'b0, `ADDR_ADDRESS, 32'h0);
      check(rd, 32'h0005);
      $display("wide test done");
   endtask
   task automatic test_stall;
      logic b;
      integer s0, i0;
      apb(1'b1, `ADDR_MODE, mw(`IRQ_STALL, `INC_NONE, 1'b0, `PM_MASTER2, 2'h1, 4'hf));
      s0 = stall_cnt;
      i0 = irq_cnt;
      apb(1'b1, `ADDR_DATA, 32'h77);
      wait_idle(b);
      check({31'h0, stall_cnt != s0}, 32'h1);
      check(irq_cnt - i0, 32'h0);
      $display("stall test done");
   endtask
   task automatic test_slave;
      integer i, i0;
      apb(1'b1, `ADDR_MODE, mw(`IRQ_BUFFER3, `INC_NONE, 1'b0, `PM_ENHANCED, 2'h0, 4'h0));
      apb(1'b1, `ADDR_OUT_WORD_ONE, 32'h1234);
      rd_status(32'h000c);
      host(1'b0, 2'h1, 8'h00);
      check({23'h0, hoe, hq}, 32'h112);
      rd_status(32'h000e);
      host(1'b0, 2'h2, 8'h00);
      rd_status(32'h004e);
      i0 = irq_cnt;
      for (i = 0; i < 4; i = i + 1) host(1'b1, i[1:0], 8'ha0 + i[7:0]);
      check(irq_cnt - i0, 32'h1);
      rd_status(32'h8f4e);
      host(1'b1, 2'h0, 8'h55);
      rd_status(32'hcf4e);
      apb(1'b0, `ADDR_IN_WORD_TWO, 32'h0);
      check(rd & 32'hffff, 32'ha3a2);
      rd_status(32'h434e);
      apb(1'b1, `ADDR_STATUS, 32'h0);
      rd_status(32'h030e);
      $display("slave test done");
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      test_reset;
      test_timing;
      test_wide;
      test_stall;
      test_slave;
      give_verdict;
   end
endmodule // parallel_master_slave_port_test
bind parallel_master_slave_port pport_chk pport_chk_inst (.pclk, .presetn, .psel, .penable,
   .pwrite, .pready, .port_irq, .cpu_stall, .write_strobe, .address_latch_low,
   .port_address_oe);
